// File: ftcu_top.sv
// Four counter/timer unit: two classic timers, two auto-reload timers
`timescale 1ns/10ps
`include "ftcu_defs.svh"
// Function
// - Four 16-bit timers: two classic-compatible, two auto-reload general purpose.
// - Timers 0 and 1 offer 13-bit, 16-bit and 8-bit auto-reload modes.
// - Split into two 8-bit counters works on timer 0 only.
// - Timers 2 and 3 run 16-bit auto-reload or two 8-bit auto-reload.
// - Timers 2 and 3 capture their count on oscillator or comparator period events.
// - Timers 0 and 1 pick one of five clocks via selects and scale.
// - Scale field makes prescaled clock; timers 0 and 1 each take it or system clock.
// - Timers 2 and 3 run from system clock or system clock over 12.
// - Timer 2 also runs from low-frequency oscillator over 8 or comparator 0.
// - Timer 3 also runs from external oscillator over 8 or comparator 1.
// - Counter mode increments on each falling edge of the event pin.
// - Events up to a quarter of the system clock are counted.
// - Timers measure intervals, count events and raise periodic interrupts.
// - Timer 0 clock select is ignored while counting pin events, except by the split high byte.
// - Timer 0 select one means system clock, zero means prescaled clock.
module ftcu_top (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [`FTCU_AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic timer0_event_pin,
  input wire logic timer1_event_pin,
  input wire logic comp0_out,
  input wire logic comp1_out,
  input wire logic lfo_clock,
  input wire logic ext_osc_clock,
  output logic irq
);
  import ftcu_pkg::*;

  logic [`FTCU_NPIN-1:0] pin_meta;
  logic [`FTCU_NPIN-1:0] pin_sync;
  logic [`FTCU_NPIN-1:0] pin_last;
  logic [`FTCU_NPIN-1:0] pin_fall;
  logic [`FTCU_NPIN-1:0] pin_rise;
  logic [7:0] ck_ctl;
  logic [7:0] t01_md;
  logic [7:0] t0_lo;
  logic [7:0] t0_hi;
  logic [7:0] t1_lo;
  logic [7:0] t1_hi;
  logic [7:0] t2_ctl;
  logic [7:0] t3_ctl;
  logic [7:0] stat;
  logic [7:0] mask;
  logic [7:0] next_rdata;
  logic [7:0] stat_clr;
  logic [7:0] stat_set;
  logic [3:0] div12_cnt;
  logic [1:0] div4_cnt;
  logic [5:0] div48_cnt;
  logic [2:0] lfo_div;
  logic [2:0] xosc_div;
  logic tick12;
  logic tick4;
  logic tick48;
  logic lfo8;
  logic xosc8;
  logic pre_tick;
  logic [1:0] clock_prescale_field;
  logic timer0_clock_select;
  logic timer1_clock_select;
  logic timer0_counter_mode_select;
  logic timer1_counter_mode_select;
  ftcu_t01_mode_t t0_mode;
  ftcu_t01_mode_t t1_mode;
  logic t0_run;
  logic t1_run;
  logic t0_split;
  logic tick0;
  logic tick1;
  logic tmr_tick0;
  logic wr_t0l;
  logic wr_t0h;
  logic wr_t1l;
  logic wr_t1h;
  logic t0_adv;
  logic t0h_adv;
  logic t1_adv;
  logic [16:0] t0_step;
  logic [16:0] t1_step;
  logic [8:0] t0_split_lo;
  logic t0_ovf;
  logic t0h_ovf;
  logic t1_ovf;

  ftcu_tmr_if t2_if ();
  ftcu_tmr_if t3_if ();

  // One step of a classic timer; returns {overflow, high, low}
  function automatic logic [16:0] ftcu_step(input ftcu_t01_mode_t m, input logic [7:0] lo,
                                            input logic [7:0] hi);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0] s8;
    logic [16:0] r;
    s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    s16 = {1'b0, hi, lo} + 17'h00001;
    s8 = {1'b0, lo} + 9'h001;
    case (m)
      FTCU_MODE_13: r = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
      FTCU_MODE_16: r = s16;
      FTCU_MODE_8R: r = {s8[8], hi, s8[8] ? hi : s8[7:0]};
      default: r = {1'b0, hi, lo};
    endcase
    return r;
  endfunction

  function automatic logic src_tick(input ftcu_src_t s, input logic t12, input logic o8,
                                    input logic cr);
    logic r;
    case (s)
      FTCU_SRC_SYS: r = 1'b1;
      FTCU_SRC_DIV12: r = t12;
      FTCU_SRC_OSC8: r = o8;
      FTCU_SRC_CMP: r = cr;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Two flops, then a third for edge detection; pin levels come from other domains
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_last <= '0;
    end else begin
      pin_meta <= {ext_osc_clock, lfo_clock, comp1_out, comp0_out,
                   timer1_event_pin, timer0_event_pin};
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  // Two-cycle hold by the source keeps a level from slipping between samples
  assign pin_fall = pin_last & ~pin_sync;
  assign pin_rise = pin_sync & ~pin_last;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div12_cnt <= '0;
      div4_cnt <= '0;
      div48_cnt <= '0;
    end else begin
      div12_cnt <= tick12 ? '0 : div12_cnt + 4'h1;
      div4_cnt <= div4_cnt + 2'h1;
      div48_cnt <= tick48 ? '0 : div48_cnt + 6'h01;
    end
  end

  assign tick12 = div12_cnt == `FTCU_DIV12_LAST;
  assign tick4 = div4_cnt == `FTCU_DIV4_LAST;
  assign tick48 = div48_cnt == `FTCU_DIV48_LAST;

  // Slow oscillators are divided on their own sampled rising edges
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lfo_div <= '0;
      xosc_div <= '0;
    end else begin
      if (pin_rise[`FTCU_P_LFO]) begin
        lfo_div <= lfo_div + 3'h1;
      end
      if (pin_rise[`FTCU_P_XOSC]) begin
        xosc_div <= xosc_div + 3'h1;
      end
    end
  end

  assign lfo8 = pin_rise[`FTCU_P_LFO] && lfo_div == `FTCU_OSC8_LAST;
  assign xosc8 = pin_rise[`FTCU_P_XOSC] && xosc_div == `FTCU_OSC8_LAST;

  assign clock_prescale_field = ck_ctl[`FTCU_CK_SCA_HI:`FTCU_CK_SCA_LO];
  assign timer0_clock_select = ck_ctl[`FTCU_CK_T0SEL];
  assign timer1_clock_select = ck_ctl[`FTCU_CK_T1SEL];
  assign timer0_counter_mode_select = t01_md[`FTCU_MD_T0CNT];
  assign timer1_counter_mode_select = t01_md[`FTCU_MD_T1CNT];
  assign t0_mode = ftcu_t01_mode_t'(t01_md[`FTCU_MD_T0M_HI:`FTCU_MD_T0M_LO]);
  assign t1_mode = ftcu_t01_mode_t'(t01_md[`FTCU_MD_T1M_HI:`FTCU_MD_T1M_LO]);
  assign t0_run = t01_md[`FTCU_MD_T0RUN];
  assign t1_run = t01_md[`FTCU_MD_T1RUN];
  assign t0_split = t0_mode == FTCU_MODE_SPLIT;

  always_comb begin
    case (clock_prescale_field)
      2'h0: pre_tick = tick12;
      2'h1: pre_tick = tick4;
      2'h2: pre_tick = tick48;
      default: pre_tick = xosc8;
    endcase
  end

  assign tmr_tick0 = timer0_clock_select ? 1'b1 : pre_tick;
  assign tick0 = timer0_counter_mode_select ? pin_fall[`FTCU_P_T0] : tmr_tick0;
  assign tick1 = timer1_counter_mode_select ? pin_fall[`FTCU_P_T1] :
                 (timer1_clock_select ? 1'b1 : pre_tick);

  assign wr_t0l = reg_wr && reg_addr == `FTCU_A_T0L;
  assign wr_t0h = reg_wr && reg_addr == `FTCU_A_T0H;
  assign wr_t1l = reg_wr && reg_addr == `FTCU_A_T1L;
  assign wr_t1h = reg_wr && reg_addr == `FTCU_A_T1H;

  assign t0_step = ftcu_step(t0_mode, t0_lo, t0_hi);
  assign t1_step = ftcu_step(t1_mode, t1_lo, t1_hi);
  assign t0_split_lo = {1'b0, t0_lo} + 9'h001;

  // A bus write to either byte suspends the step; the split high byte stops only for its own write
  assign t0_adv = t0_run && tick0 && !wr_t0l && !wr_t0h;
  assign t0h_adv = t0_split && t1_run && tmr_tick0 && !wr_t0h;
  // While timer 0 is split, timer 1 runs free but raises no flag
  assign t1_adv = (t1_run || t0_split) && tick1 && !wr_t1l && !wr_t1h &&
                  t1_mode != FTCU_MODE_SPLIT;

  assign t0_ovf = t0_adv && (t0_split ? t0_split_lo[8] : t0_step[16]);
  assign t0h_ovf = t0h_adv && &t0_hi;
  assign t1_ovf = t1_adv && !t0_split && t1_step[16];

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      t0_lo <= `FTCU_RST_BYTE;
    end else if (wr_t0l) begin
      t0_lo <= reg_wdata;
    end else if (t0_adv) begin
      t0_lo <= t0_split ? t0_split_lo[7:0] : t0_step[7:0];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      t0_hi <= `FTCU_RST_BYTE;
    end else if (wr_t0h) begin
      t0_hi <= reg_wdata;
    end else if (t0_split) begin
      if (t0h_adv) begin
        t0_hi <= t0_hi + 8'h01;
      end
    end else if (t0_adv) begin
      t0_hi <= t0_step[15:8];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      t1_lo <= `FTCU_RST_BYTE;
      t1_hi <= `FTCU_RST_BYTE;
    end else if (wr_t1l || wr_t1h) begin
      if (wr_t1l) begin
        t1_lo <= reg_wdata;
      end
      if (wr_t1h) begin
        t1_hi <= reg_wdata;
      end
    end else if (t1_adv) begin
      t1_lo <= t1_step[7:0];
      t1_hi <= t1_step[15:8];
    end
  end

  // Auto-reload timers 2 and 3
  assign t2_if.wdata = reg_wdata;
  assign t2_if.wr_cnt_lo = reg_wr && reg_addr == `FTCU_A_T2L;
  assign t2_if.wr_cnt_hi = reg_wr && reg_addr == `FTCU_A_T2H;
  assign t2_if.wr_rl_lo = reg_wr && reg_addr == `FTCU_A_T2RL;
  assign t2_if.wr_rl_hi = reg_wr && reg_addr == `FTCU_A_T2RH;
  assign t2_if.run = t2_ctl[`FTCU_TC_RUN];
  assign t2_if.split = t2_ctl[`FTCU_TC_SPLIT];
  assign t2_if.capture = t2_ctl[`FTCU_TC_CAPT];
  assign t2_if.tick = src_tick(ftcu_src_t'(t2_ctl[`FTCU_TC_SRC_HI:`FTCU_TC_SRC_LO]),
                               tick12, lfo8, pin_rise[`FTCU_P_CMP0]);
  assign t2_if.cap_evt = t2_ctl[`FTCU_TC_CAPSRC] ? pin_rise[`FTCU_P_CMP0] : lfo8;

  assign t3_if.wdata = reg_wdata;
  assign t3_if.wr_cnt_lo = reg_wr && reg_addr == `FTCU_A_T3L;
  assign t3_if.wr_cnt_hi = reg_wr && reg_addr == `FTCU_A_T3H;
  assign t3_if.wr_rl_lo = reg_wr && reg_addr == `FTCU_A_T3RL;
  assign t3_if.wr_rl_hi = reg_wr && reg_addr == `FTCU_A_T3RH;
  assign t3_if.run = t3_ctl[`FTCU_TC_RUN];
  assign t3_if.split = t3_ctl[`FTCU_TC_SPLIT];
  assign t3_if.capture = t3_ctl[`FTCU_TC_CAPT];
  assign t3_if.tick = src_tick(ftcu_src_t'(t3_ctl[`FTCU_TC_SRC_HI:`FTCU_TC_SRC_LO]),
                               tick12, xosc8, pin_rise[`FTCU_P_CMP1]);
  assign t3_if.cap_evt = t3_ctl[`FTCU_TC_CAPSRC] ? pin_rise[`FTCU_P_CMP1] : xosc8;

  ftcu_reload_timer u_timer2 (
    .clock(clock),
    .rst_b(rst_b),
    .bus(t2_if.tmr)
  );

  ftcu_reload_timer u_timer3 (
    .clock(clock),
    .rst_b(rst_b),
    .bus(t3_if.tmr)
  );

  // Configuration registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ck_ctl <= `FTCU_RST_BYTE;
      t01_md <= `FTCU_RST_BYTE;
      t2_ctl <= `FTCU_RST_BYTE;
      t3_ctl <= `FTCU_RST_BYTE;
      mask <= `FTCU_RST_BYTE;
    end else if (reg_wr) begin
      case (reg_addr)
        `FTCU_A_CKCTL: ck_ctl <= reg_wdata & `FTCU_CK_USED;
        `FTCU_A_T01MD: t01_md <= reg_wdata;
        `FTCU_A_T2CTL: t2_ctl <= reg_wdata & `FTCU_TC_USED;
        `FTCU_A_T3CTL: t3_ctl <= reg_wdata & `FTCU_TC_USED;
        `FTCU_A_MASK: mask <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Sticky flags: write one clears, a new event in the same cycle wins
  assign stat_clr = (reg_wr && reg_addr == `FTCU_A_STAT) ? reg_wdata : 8'h00;

  always_comb begin
    stat_set = 8'h00;
    stat_set[`FTCU_ST_T0] = t0_ovf;
    stat_set[`FTCU_ST_T1] = t1_ovf || t0h_ovf;
    stat_set[`FTCU_ST_T2L] = t2_if.ovf_lo;
    stat_set[`FTCU_ST_T2H] = t2_if.ovf_hi;
    stat_set[`FTCU_ST_T3L] = t3_if.ovf_lo;
    stat_set[`FTCU_ST_T3H] = t3_if.ovf_hi;
    stat_set[`FTCU_ST_T2C] = t2_if.cap_done;
    stat_set[`FTCU_ST_T3C] = t3_if.cap_done;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stat <= `FTCU_RST_BYTE;
    end else begin
      stat <= (stat & ~stat_clr) | stat_set;
    end
  end

  assign irq = |(stat & mask);

  always_comb begin
    case (reg_addr)
      `FTCU_A_CKCTL: next_rdata = ck_ctl;
      `FTCU_A_T01MD: next_rdata = t01_md;
      `FTCU_A_T0L: next_rdata = t0_lo;
      `FTCU_A_T0H: next_rdata = t0_hi;
      `FTCU_A_T1L: next_rdata = t1_lo;
      `FTCU_A_T1H: next_rdata = t1_hi;
      `FTCU_A_T2CTL: next_rdata = t2_ctl;
      `FTCU_A_T2L: next_rdata = t2_if.cnt[7:0];
      `FTCU_A_T2H: next_rdata = t2_if.cnt[15:8];
      `FTCU_A_T2RL: next_rdata = t2_if.rl[7:0];
      `FTCU_A_T2RH: next_rdata = t2_if.rl[15:8];
      `FTCU_A_T3CTL: next_rdata = t3_ctl;
      `FTCU_A_T3L: next_rdata = t3_if.cnt[7:0];
      `FTCU_A_T3H: next_rdata = t3_if.cnt[15:8];
      `FTCU_A_T3RL: next_rdata = t3_if.rl[7:0];
      `FTCU_A_T3RH: next_rdata = t3_if.rl[15:8];
      `FTCU_A_STAT: next_rdata = stat;
      `FTCU_A_MASK: next_rdata = mask;
      default: next_rdata = 8'h00;
    endcase
  end

  // Data shows only in the cycle after the read strobe
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 8'h00;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  sequence s_t0_plain16;
    t0_adv && t0_mode == FTCU_MODE_16 && !(&t0_lo);
  endsequence

  sequence s_t0_pin_event;
    timer0_counter_mode_select && pin_fall[`FTCU_P_T0];
  endsequence

  chk_t0_event_count: assert property (s_t0_pin_event ##0 s_t0_plain16 |=>
      t0_lo == $past(t0_lo) + 8'h01)
    else $error("timer 0 missed a pin event");
  // Split high byte keeps its own clock even in counter mode
  chk_t0_select_ignored: assert property (timer0_counter_mode_select && !t0_split &&
      !pin_fall[`FTCU_P_T0] && !wr_t0l && !wr_t0h |=> $stable(t0_lo) && $stable(t0_hi))
    else $error("timer 0 counted without a pin event");
  chk_t0_sysclk_run: assert property (!timer0_counter_mode_select && timer0_clock_select &&
      t0_run && t0_mode == FTCU_MODE_16 && !wr_t0l && !wr_t0h && !(&t0_lo) |=>
      t0_lo == $past(t0_lo) + 8'h01)
    else $error("timer 0 not stepping on system clock");
  chk_t1_split_hold: assert property (t1_mode == FTCU_MODE_SPLIT && !wr_t1l && !wr_t1h |=>
      $stable({t1_hi, t1_lo}))
    else $error("timer 1 moved in split mode");
  chk_t0_auto_reload: assert property (t0_adv && t0_mode == FTCU_MODE_8R && &t0_lo |=>
      t0_lo == $past(t0_hi) && stat[`FTCU_ST_T0])
    else $error("timer 0 8-bit reload failed");
  chk_t0_13bit_wrap: assert property (t0_adv && t0_mode == FTCU_MODE_13 &&
      &t0_hi && &t0_lo[4:0] |=> t0_hi == 8'h00 && t0_lo[4:0] == 5'h00 && stat[`FTCU_ST_T0])
    else $error("timer 0 13-bit wrap wrong");
  chk_div12_period: assert property (tick12 |=> !tick12 [*8] ##1 !tick12 ##1 !tick12
      ##1 !tick12 ##1 tick12)
    else $error("divide-by-12 tick period wrong");
  chk_flag_sticky: assert property (1'b1 |=>
      ((stat & $past(stat & ~stat_clr)) == $past(stat & ~stat_clr)))
    else $error("status flag lost without a clear");
  chk_irq_masked: assert property (t0_ovf && mask[`FTCU_ST_T0] &&
      !(reg_wr && reg_addr == `FTCU_A_MASK) |=> irq)
    else $error("unmasked overflow raised no interrupt");
endmodule

// File: ftcu_defs.svh
// Register map, field positions and divider counts of the four timer unit
`ifndef FTCU_DEFS_SVH
`define FTCU_DEFS_SVH

`define FTCU_AW 5
`define FTCU_A_CKCTL 5'h00
`define FTCU_A_T01MD 5'h01
`define FTCU_A_T0L 5'h02
`define FTCU_A_T0H 5'h03
`define FTCU_A_T1L 5'h04
`define FTCU_A_T1H 5'h05
`define FTCU_A_T2CTL 5'h06
`define FTCU_A_T2L 5'h07
`define FTCU_A_T2H 5'h08
`define FTCU_A_T2RL 5'h09
`define FTCU_A_T2RH 5'h0A
`define FTCU_A_T3CTL 5'h0B
`define FTCU_A_T3L 5'h0C
`define FTCU_A_T3H 5'h0D
`define FTCU_A_T3RL 5'h0E
`define FTCU_A_T3RH 5'h0F
`define FTCU_A_STAT 5'h10
`define FTCU_A_MASK 5'h11

`define FTCU_RST_BYTE 8'h00

// Clock control byte
`define FTCU_CK_SCA_LO 0
`define FTCU_CK_SCA_HI 1
`define FTCU_CK_T0SEL 2
`define FTCU_CK_T1SEL 3
`define FTCU_CK_USED 8'h0F

// Timer 0/1 mode byte
`define FTCU_MD_T0M_LO 0
`define FTCU_MD_T0M_HI 1
`define FTCU_MD_T0CNT 2
`define FTCU_MD_T0RUN 3
`define FTCU_MD_T1M_LO 4
`define FTCU_MD_T1M_HI 5
`define FTCU_MD_T1CNT 6
`define FTCU_MD_T1RUN 7

// Timer 2/3 control byte
`define FTCU_TC_RUN 0
`define FTCU_TC_SPLIT 1
`define FTCU_TC_CAPT 2
`define FTCU_TC_SRC_LO 3
`define FTCU_TC_SRC_HI 4
`define FTCU_TC_CAPSRC 5
`define FTCU_TC_USED 8'h3F

// Status and mask bits
`define FTCU_ST_T0 0
`define FTCU_ST_T1 1
`define FTCU_ST_T2L 2
`define FTCU_ST_T2H 3
`define FTCU_ST_T3L 4
`define FTCU_ST_T3H 5
`define FTCU_ST_T2C 6
`define FTCU_ST_T3C 7

// Synchronised pin indices
`define FTCU_NPIN 6
`define FTCU_P_T0 0
`define FTCU_P_T1 1
`define FTCU_P_CMP0 2
`define FTCU_P_CMP1 3
`define FTCU_P_LFO 4
`define FTCU_P_XOSC 5

// Terminal counts of the dividers
`define FTCU_DIV12_LAST 4'hB
`define FTCU_DIV4_LAST 2'h3
`define FTCU_DIV48_LAST 6'h2F
`define FTCU_OSC8_LAST 3'h7

`endif

// File: ftcu_pkg.sv
// Types shared by the four timer unit
package ftcu_pkg;
  typedef enum logic [1:0] {
    FTCU_MODE_13 = 2'h0,
    FTCU_MODE_16 = 2'h1,
    FTCU_MODE_8R = 2'h2,
    FTCU_MODE_SPLIT = 2'h3
  } ftcu_t01_mode_t;

  typedef enum logic [1:0] {
    FTCU_SRC_SYS = 2'h0,
    FTCU_SRC_DIV12 = 2'h1,
    FTCU_SRC_OSC8 = 2'h2,
    FTCU_SRC_CMP = 2'h3
  } ftcu_src_t;
endpackage

// File: ftcu_tmr_if.sv
// Link between the unit top and one auto-reload timer
`timescale 1ns/10ps
interface ftcu_tmr_if;
  logic [7:0] wdata;
  logic wr_cnt_lo;
  logic wr_cnt_hi;
  logic wr_rl_lo;
  logic wr_rl_hi;
  logic run;
  logic split;
  logic capture;
  logic tick;
  logic cap_evt;
  logic [15:0] cnt;
  logic [15:0] rl;
  logic ovf_lo;
  logic ovf_hi;
  logic cap_done;

  modport ctrl (
    output wdata, wr_cnt_lo, wr_cnt_hi, wr_rl_lo, wr_rl_hi, run, split, capture, tick,
    output cap_evt,
    input cnt, rl, ovf_lo, ovf_hi, cap_done
  );
  modport tmr (
    input wdata, wr_cnt_lo, wr_cnt_hi, wr_rl_lo, wr_rl_hi, run, split, capture, tick,
    input cap_evt,
    output cnt, rl, ovf_lo, ovf_hi, cap_done
  );
endinterface

// File: ftcu_reload_timer.sv
// Auto-reload timer with 16-bit, split 8-bit and capture modes
`timescale 1ns/10ps
`include "ftcu_defs.svh"
module ftcu_reload_timer (
  input wire logic clock,
  input wire logic rst_b,
  ftcu_tmr_if.tmr bus
);
  import ftcu_pkg::*;

  logic adv;
  logic lo_full;
  logic hi_full;

  assign adv = bus.run && bus.tick && !bus.wr_cnt_lo && !bus.wr_cnt_hi;
  assign lo_full = &bus.cnt[7:0];
  assign hi_full = &bus.cnt[15:8];

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bus.cnt <= {2{`FTCU_RST_BYTE}};
    end else if (adv) begin
      if (bus.split) begin
        bus.cnt[7:0] <= lo_full ? bus.rl[7:0] : bus.cnt[7:0] + 8'h01;
        bus.cnt[15:8] <= hi_full ? bus.rl[15:8] : bus.cnt[15:8] + 8'h01;
      end else if (bus.capture || !(lo_full && hi_full)) begin
        bus.cnt <= bus.cnt + 16'h0001;
      end else begin
        bus.cnt <= bus.rl;
      end
    end else begin
      if (bus.wr_cnt_lo) begin
        bus.cnt[7:0] <= bus.wdata;
      end
      if (bus.wr_cnt_hi) begin
        bus.cnt[15:8] <= bus.wdata;
      end
    end
  end

  // Capture beats a bus write to the reload bytes in the same cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bus.rl <= {2{`FTCU_RST_BYTE}};
    end else if (bus.capture && bus.cap_evt) begin
      bus.rl <= bus.cnt;
    end else begin
      if (bus.wr_rl_lo) begin
        bus.rl[7:0] <= bus.wdata;
      end
      if (bus.wr_rl_hi) begin
        bus.rl[15:8] <= bus.wdata;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bus.ovf_lo <= 1'b0;
      bus.ovf_hi <= 1'b0;
      bus.cap_done <= 1'b0;
    end else begin
      bus.ovf_lo <= adv && bus.split && lo_full;
      bus.ovf_hi <= adv && hi_full && (bus.split || lo_full);
      bus.cap_done <= bus.capture && bus.cap_evt;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  sequence s_full_wrap;
    adv && !bus.split && !bus.capture && lo_full && hi_full;
  endsequence

  chk_reload_on_wrap: assert property (s_full_wrap |=> bus.cnt == $past(bus.rl) && bus.ovf_hi)
    else $error("16-bit wrap did not reload or flag");
  chk_capture_copy: assert property (bus.capture && bus.cap_evt |=>
      bus.rl == $past(bus.cnt) && bus.cap_done)
    else $error("capture did not copy the count");
endmodule

// File: ftcu_far_side.sv
// Far side model: event pins, comparators and slow oscillators
`timescale 1ns/10ps
module ftcu_far_side (
  input wire logic clock,
  output logic [3:0] pins,
  output logic lfo_clock,
  output logic ext_osc_clock
);
  // Event pins idle high, comparators idle low
  initial begin
    pins = 4'h3;
    lfo_clock = 1'b0;
    ext_osc_clock = 1'b0;
  end
  // Free running, phase unrelated to the system clock
  always #200 lfo_clock = ~lfo_clock;
  always #170 ext_osc_clock = ~ext_osc_clock;
  // Each level held two cycles: fastest legal rate
  task automatic pulses(input int i, input int n);
    for (int k = 0; k < 2 * n; k++) begin
      @(posedge clock);
      pins[i] <= ~pins[i];
      @(posedge clock);
    end
  endtask
endmodule

// File: test_four_timer_counter_unit.sv
// Self-checking bench of the four timer unit
`timescale 1ns/10ps
module test_four_timer_counter_unit;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic irq;
  logic [3:0] pins;
  logic lfo_clock;
  logic ext_osc_clock;
  logic [7:0] v;
  logic [7:0] d;
  logic [12:0] s[$];
  logic [4:0] wa[6] = '{5'h00, 5'h09, 5'h0A, 5'h0E, 5'h0F, 5'h1F};
  logic [7:0] wm[6] = '{8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};
  logic [4:0] ca[4] = '{5'h02, 5'h04, 5'h07, 5'h0C};
  int bad_count = 0;
  int n_compared = 0;
  int n[4];
  // Clock control, control addr, control, count addr, cycles, expected count
  int t[13][6] = '{
    '{4, 1, 9, 2, 100, 100}, '{1, 1, 9, 2, 200, 50}, '{0, 1, 9, 2, 240, 20},
    '{2, 1, 9, 2, 960, 20}, '{3, 1, 9, 2, 1088, 20}, '{8, 1, 144, 4, 100, 100},
    '{4, 1, 8, 2, 40, 8}, '{4, 1, 13, 2, 100, 0}, '{0, 6, 1, 7, 100, 100},
    '{0, 6, 9, 7, 240, 20}, '{0, 6, 17, 7, 1280, 20}, '{0, 11, 9, 12, 240, 20},
    '{0, 11, 17, 12, 1088, 20}};

  always #25 clock = ~clock;

  ftcu_far_side far (.clock(clock), .pins(pins), .lfo_clock(lfo_clock),
    .ext_osc_clock(ext_osc_clock));
  ftcu_top uut (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer0_event_pin(pins[0]),
    .timer1_event_pin(pins[1]), .comp0_out(pins[2]), .comp1_out(pins[3]),
    .lfo_clock(lfo_clock), .ext_osc_clock(ext_osc_clock), .irq(irq));

  task print_verdict;
    $display("mismatches %0d, comparisons %0d", bad_count, n_compared);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Free-running dividers may add a tick at either end of the window
  function automatic logic [7:0] in_window(input logic [7:0] seen, input int e);
    return {7'h0, seen + 1 >= e && seen <= e + 3};
  endfunction

  task wr(input logic [4:0] a, input logic [7:0] dd);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= dd;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task rd(input logic [4:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task play;
    foreach (s[i]) wr(s[i][12:8], s[i][7:0]);
  endtask

  task wait_irq;
    for (int k = 0; k < 400 && irq !== 1'b1; k++) begin
      @(posedge clock);
      #1;
    end
    check({7'h0, irq}, 8'h01);
    if (irq !== 1'b1) print_verdict();
  endtask

  task ovf_case(input logic [12:0] stop, input logic [7:0] st, input logic [4:0] ha,
      input logic [7:0] he);
    wait_irq();
    wr(stop[12:8], stop[7:0]);
    rd(5'h10);
    check(v, st);
    rd(ha);
    check(v, he);
    wr(5'h11, 8'h00);
    #1 check({7'h0, irq}, 8'h00);
    wr(5'h10, st);
    rd(5'h10);
    check(v, 8'h00);
  endtask

  initial begin
    void'($urandom(32'hCBBD));
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    for (int a = 0; a < 32; a++) begin
      rd(a[4:0]);
      check(v, 8'h00);
    end
    foreach (wa[i]) begin
      d = 8'($urandom);
      wr(wa[i], d);
      rd(wa[i]);
      check(v, d & wm[i]);
    end
    foreach (t[i]) begin
      wr(5'h00, 8'(t[i][0]));
      wr(5'(t[i][3]), 8'h00);
      wr(5'(t[i][3] + 1), 8'h00);
      wr(5'(t[i][1]), 8'(t[i][2]));
      repeat (t[i][4]) @(posedge clock);
      wr(5'(t[i][1]), 8'h00);
      rd(5'(t[i][3]));
      check(in_window(v, t[i][5]), 8'h01);
    end
    for (int a = 1; a < 16; a++) wr(a[4:0], 8'h00);
    s = '{13'h0004, 13'h01DD, 13'h0619, 13'h0B19};
    play();
    foreach (n[i]) n[i] = 1 + $urandom % 40;
    fork
      far.pulses(0, n[0]);
      far.pulses(1, n[1]);
      far.pulses(2, n[2]);
      far.pulses(3, n[3]);
    join
    repeat (8) @(posedge clock);
    s = '{13'h0100, 13'h0600, 13'h0B00, 13'h10FF};
    play();
    foreach (n[i]) begin
      rd(ca[i]);
      check(v, 8'(n[i]));
    end
    s = '{13'h1101, 13'h02FE, 13'h03F0, 13'h010A};
    play();
    ovf_case(13'h0100, 8'h01, 5'h03, 8'hF0);
    // 13-bit wrap on timer 0 while timer 1 sits in the split code
    s = '{13'h1101, 13'h021E, 13'h03FF, 13'h045A, 13'h01B8};
    play();
    ovf_case(13'h0100, 8'h01, 5'h03, 8'h00);
    rd(5'h04);
    check(v, 8'h5A);
    s = '{13'h1108, 13'h0900, 13'h0AFF, 13'h07FE, 13'h08FF, 13'h0601};
    play();
    ovf_case(13'h0600, 8'h08, 5'h08, 8'hFF);
    s = '{13'h1110, 13'h0EF0, 13'h0CFE, 13'h0D00, 13'h0B03};
    play();
    ovf_case(13'h0B00, 8'h10, 5'h10, 8'h10);
    s = '{13'h1140, 13'h0700, 13'h0800, 13'h0625};
    play();
    far.pulses(2, 1);
    ovf_case(13'h0600, 8'h40, 5'h10, 8'h40);
    print_verdict();
  end
endmodule
